/* include/srufc_pkg.sv */
// Constants for the serial receive user-frame configuration block
package srufc_pkg;
    localparam int CH_NUM = 2;
    localparam int COMBO_NUM = 4;
    localparam int SLOT_NUM = 2 * COMBO_NUM;
    localparam int IDX_W = 12;
    // Register word indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MON = 12'h040;
    localparam logic [IDX_W-1:0] IDX_USE_CH1 = 12'h0ad;
    localparam logic [IDX_W-1:0] IDX_FRAME_CH1 = 12'h0ae;
    localparam logic [IDX_W-1:0] IDX_TXESC_CH1 = 12'h11f;
    localparam logic [IDX_W-1:0] IDX_RXESC_CH1 = 12'h120;
    localparam logic [IDX_W-1:0] IDX_CONV_CH1 = 12'h121;
    localparam logic [IDX_W-1:0] IDX_USE_CH2 = 12'h14d;
    localparam logic [IDX_W-1:0] IDX_FRAME_CH2 = 12'h14e;
    localparam logic [IDX_W-1:0] IDX_TXESC_CH2 = 12'h1bf;
    localparam logic [IDX_W-1:0] IDX_RXESC_CH2 = 12'h1c0;
    localparam logic [IDX_W-1:0] IDX_CONV_CH2 = 12'h1c1;
    localparam logic [IDX_W-1:0] IDX_STATUS = 12'h300;
    localparam logic [IDX_W-1:0] IDX_MASK = 12'h301;
    localparam logic [IDX_W-1:0] IDX_END_CH1 = 12'h302;
    localparam logic [IDX_W-1:0] IDX_END_CH2 = 12'h303;
    // Frame-use, monitoring and reset word values
    localparam logic [15:0] USE_REQ = 16'h0001;
    localparam logic [15:0] USE_READY = 16'h0002;
    localparam logic [15:0] MON_HIGH = 16'h0001;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Valid frame number ranges
    localparam logic [15:0] FR_DEF_LO = 16'h0001;
    localparam logic [15:0] FR_DEF_HI = 16'h03e7;
    localparam logic [15:0] FR_EE_LO = 16'h03e8;
    localparam logic [15:0] FR_EE_HI = 16'h04af;
    localparam logic [15:0] FR_BUF_LO = 16'h8001;
    localparam logic [15:0] FR_BUF_HI = 16'h801f;
    // Escape word fields
    localparam int ESC_ADD_LSB = 8;
    localparam int ESC_TRN_LSB = 0;
    // Status and mask bit positions (plus channel number)
    localparam int ST_RDREQ = 0;
    localparam int ST_READY = 2;
    localparam int ST_HOSTREQ = 4;
    localparam int ST_W = 6;
    // Monitoring timing
    localparam int CLK_MHZ = 100;
    localparam int MON_COMPAT_MS = 10;
    localparam int MON_SAVE_MS = 5;
    localparam int MON_COMPAT_CYC = MON_COMPAT_MS * 1000 * CLK_MHZ;
    localparam int MON_FAST_CYC = (MON_COMPAT_MS - MON_SAVE_MS) * 1000 * CLK_MHZ;
    localparam int MON_CNT_W = 24;
    // True when a frame number lies in one of the three registered ranges
    function automatic logic frame_ok(input logic [15:0] no);
        frame_ok = (no >= FR_DEF_LO && no <= FR_DEF_HI) || (no >= FR_EE_LO && no <= FR_EE_HI)
            || (no >= FR_BUF_LO && no <= FR_BUF_HI);
    endfunction : frame_ok
endpackage : srufc_pkg

/* rtl/srufc_top.sv */
// Receive user-frame matcher, escape and text conversion, APB registers
// Functional notes
// - At most four header/trailer combinations per channel
// - Trailer after matching header raises read request
// - Only the three frame number ranges are valid
// - Host writes 1, device replaces with 2
// - No new transmit byte accepted while the frame-use word reads 1; queued bytes still drain
// - Separate transmit and receive escape pair words
// - Byte after additional code is never control data
// - Text conversion on transmit and on receive
// - High-speed polling accepts requests about 5 ms sooner
// - Monitoring word value 1 selects high speed
// - Only configured combinations are recognised
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module srufc_top
    import srufc_pkg::*;
#(
    parameter int MON_SLOW_CYC = MON_COMPAT_CYC,
    parameter int MON_QUICK_CYC = MON_FAST_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive byte stream and frame recogniser, per channel
    input wire logic [CH_NUM-1:0] rx_valid,
    input wire logic [CH_NUM*8-1:0] rx_data,
    input wire logic [CH_NUM-1:0] rx_frame_hit,
    input wire logic [CH_NUM*16-1:0] rx_frame_no,
    // Received user data toward buffer memory
    output logic [CH_NUM-1:0] rx_out_valid,
    output logic [CH_NUM*8-1:0] rx_out_data,
    output logic [CH_NUM-1:0] rx_read_req,
    // Transmit path
    input wire logic [CH_NUM-1:0] tx_in_valid,
    input wire logic [CH_NUM*8-1:0] tx_in_data,
    output logic [CH_NUM-1:0] tx_in_ready,
    output logic [CH_NUM-1:0] tx_out_valid,
    output logic [CH_NUM*8-1:0] tx_out_data,
    // Host request signals
    input wire logic [CH_NUM-1:0] host_req,
    output logic [CH_NUM-1:0] host_req_ack,
    // Interrupt
    output logic irq
);
    if (MON_QUICK_CYC < 1 || MON_QUICK_CYC >= MON_SLOW_CYC || MON_SLOW_CYC >= (1 << MON_CNT_W))
    begin : g_bad_mon
        $error("srufc_top: monitoring periods out of range");
    end

    function automatic logic [7:0] to_text(input logic [3:0] n);
        to_text = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : to_text

    function automatic logic [3:0] from_text(input logic [7:0] c);
        if (c >= 8'h61)
        begin
            from_text = 4'(c - 8'h57);
        end
        else if (c >= 8'h41)
        begin
            from_text = 4'(c - 8'h37);
        end
        else
        begin
            from_text = 4'(c - 8'h30);
        end
    endfunction : from_text

    logic [15:0] mon_reg;
    logic [15:0] use_reg [CH_NUM];
    logic [15:0] frame_reg [CH_NUM][SLOT_NUM];
    logic [15:0] txesc_reg [CH_NUM];
    logic [15:0] rxesc_reg [CH_NUM];
    logic [15:0] conv_reg [CH_NUM];
    logic [7:0] end_reg [CH_NUM];
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic [ST_W-1:0] status_set;
    logic [IDX_W-1:0] idx;
    logic wr_en;
    logic setup;
    logic [31:0] rd_next;
    logic hit_next;

    assign idx = paddr[IDX_W+1:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && hit_next;
    assign pready = 1'b1;
    assign irq = |(status_reg & mask_reg);

    // Read decode and hit detection
    always_comb
    begin
        rd_next = 32'h0000_0000;
        hit_next = 1'b1;
        if (idx == IDX_MON)
            rd_next = {16'h0000, mon_reg};
        else if (idx == IDX_USE_CH1)
            rd_next = {16'h0000, use_reg[0]};
        else if (idx == IDX_USE_CH2)
            rd_next = {16'h0000, use_reg[1]};
        else if (idx >= IDX_FRAME_CH1 && idx < IDX_FRAME_CH1 + IDX_W'(SLOT_NUM))
            rd_next = {16'h0000, frame_reg[0][3'(idx - IDX_FRAME_CH1)]};
        else if (idx >= IDX_FRAME_CH2 && idx < IDX_FRAME_CH2 + IDX_W'(SLOT_NUM))
            rd_next = {16'h0000, frame_reg[1][3'(idx - IDX_FRAME_CH2)]};
        else if (idx == IDX_TXESC_CH1)
            rd_next = {16'h0000, txesc_reg[0]};
        else if (idx == IDX_TXESC_CH2)
            rd_next = {16'h0000, txesc_reg[1]};
        else if (idx == IDX_RXESC_CH1)
            rd_next = {16'h0000, rxesc_reg[0]};
        else if (idx == IDX_RXESC_CH2)
            rd_next = {16'h0000, rxesc_reg[1]};
        else if (idx == IDX_CONV_CH1)
            rd_next = {16'h0000, conv_reg[0]};
        else if (idx == IDX_CONV_CH2)
            rd_next = {16'h0000, conv_reg[1]};
        else if (idx == IDX_STATUS)
            rd_next = {26'h0, status_reg};
        else if (idx == IDX_MASK)
            rd_next = {26'h0, mask_reg};
        else if (idx == IDX_END_CH1)
            rd_next = {24'h0, end_reg[0]};
        else if (idx == IDX_END_CH2)
            rd_next = {24'h0, end_reg[1]};
        else
            hit_next = 1'b0;
        if (paddr[1:0] != 2'b00)
            hit_next = 1'b0;
    end

    // Read data and error captured in setup so the access phase needs no wait
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= hit_next ? rd_next : 32'h0000_0000;
            pslverr <= !hit_next;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mon_reg <= REG_RESET;
            mask_reg <= '0;
            for (int c = 0; c < CH_NUM; c++)
            begin
                use_reg[c] <= REG_RESET;
                txesc_reg[c] <= REG_RESET;
                rxesc_reg[c] <= REG_RESET;
                conv_reg[c] <= REG_RESET;
                end_reg[c] <= 8'h00;
                for (int s = 0; s < SLOT_NUM; s++)
                    frame_reg[c][s] <= REG_RESET;
            end
        end
        else
        begin
            if (wr_en && idx == IDX_MON)
                mon_reg <= pwdata[15:0];
            if (wr_en && idx == IDX_MASK)
                mask_reg <= pwdata[ST_W-1:0];
            for (int c = 0; c < CH_NUM; c++)
            begin
                if (wr_en && idx == (c == 0 ? IDX_USE_CH1 : IDX_USE_CH2))
                    use_reg[c] <= pwdata[15:0];
                else if (use_reg[c] == USE_REQ)
                    use_reg[c] <= USE_READY;
                if (wr_en && idx == (c == 0 ? IDX_TXESC_CH1 : IDX_TXESC_CH2))
                    txesc_reg[c] <= pwdata[15:0];
                if (wr_en && idx == (c == 0 ? IDX_RXESC_CH1 : IDX_RXESC_CH2))
                    rxesc_reg[c] <= pwdata[15:0];
                if (wr_en && idx == (c == 0 ? IDX_CONV_CH1 : IDX_CONV_CH2))
                    conv_reg[c] <= pwdata[15:0];
                if (wr_en && idx == (c == 0 ? IDX_END_CH1 : IDX_END_CH2))
                    end_reg[c] <= pwdata[7:0];
                for (int s = 0; s < SLOT_NUM; s++)
                    if (wr_en && idx == (c == 0 ? IDX_FRAME_CH1 : IDX_FRAME_CH2) + IDX_W'(s))
                        frame_reg[c][s] <= pwdata[15:0];
            end
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            status_reg <= '0;
        else if (wr_en && idx == IDX_STATUS)
            status_reg <= (status_reg & ~pwdata[ST_W-1:0]) | status_set;
        else
            status_reg <= status_reg | status_set;
    end

    // Host request polling; the period sets acceptance delay
    logic [MON_CNT_W-1:0] mon_cnt;
    logic mon_tick;
    logic [MON_CNT_W-1:0] mon_period;
    assign mon_period = (mon_reg == MON_HIGH) ? MON_CNT_W'(MON_QUICK_CYC - 1)
        : MON_CNT_W'(MON_SLOW_CYC - 1);
    assign mon_tick = (mon_cnt == '0);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mon_cnt <= '0;
        else if (mon_tick || mon_cnt > mon_period)
            mon_cnt <= mon_period;
        else
            mon_cnt <= mon_cnt - 1'b1;
    end

    fast_period_a: assert property (@(posedge clk) disable iff (sys_rst)
        mon_tick && mon_reg == MON_HIGH ##1 (mon_reg == MON_HIGH) [*1]
        |-> mon_cnt == MON_CNT_W'(MON_QUICK_CYC - 1))
        else $error("fast poll period wrong");

    logic [MON_CNT_W-1:0] tick_gap;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tick_gap <= '0;
        else
            tick_gap <= mon_tick ? '0 : tick_gap + 1'b1;
    end

    poll_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
        tick_gap < MON_CNT_W'(MON_SLOW_CYC))
        else $error("poll gap exceeds compatible period");

    for (genvar ch = 0; ch < CH_NUM; ch++)
    begin : g_ch
        logic [7:0] rb;
        logic [15:0] fno;
        logic active;
        logic [COMBO_NUM-1:0] hdr_hit;
        logic [COMBO_NUM-1:0] trl_any;
        logic any_hdr;
        logic esc_pend;
        logic armed;
        logic hdr_only;
        logic [1:0] armed_k;
        logic req_pulse;
        logic ctrl_ok;
        logic nib_half;
        logic [3:0] nib_hi;
        logic req_prev;
        logic [7:0] q_data [4];
        logic [2:0] q_cnt;
        logic [7:0] c_hi;
        logic [7:0] c_lo;
        logic [7:0] add_tx;
        logic [7:0] trn_tx;

        assign rb = rx_data[ch*8 +: 8];
        assign fno = rx_frame_no[ch*16 +: 16];
        assign active = (use_reg[ch] == USE_READY);
        assign ctrl_ok = rx_valid[ch] && !esc_pend;

        for (genvar k = 0; k < COMBO_NUM; k++)
        begin : g_combo
            assign hdr_hit[k] = frame_ok(frame_reg[ch][k]) && frame_reg[ch][k] == fno;
            assign trl_any[k] = frame_ok(frame_reg[ch][k+COMBO_NUM])
                && frame_reg[ch][k+COMBO_NUM] == fno
                && frame_reg[ch][k] == 16'h0000;
        end
        assign any_hdr = frame_ok(frame_reg[ch][0]);

        // Header arming and trailer match
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                esc_pend <= 1'b0;
                armed <= 1'b0;
                hdr_only <= 1'b0;
                armed_k <= 2'd0;
                req_pulse <= 1'b0;
            end
            else
            begin
                req_pulse <= 1'b0;
                if (rx_valid[ch])
                    esc_pend <= !esc_pend && rxesc_reg[ch][ESC_ADD_LSB +: 8] != 8'h00
                        && rb == rxesc_reg[ch][ESC_ADD_LSB +: 8];
                if (!active)
                    armed <= 1'b0;
                else if (ctrl_ok && rx_frame_hit[ch] && |hdr_hit)
                begin
                    armed <= 1'b1;
                    for (int k = COMBO_NUM - 1; k >= 0; k--)
                        if (hdr_hit[k])
                        begin
                            armed_k <= 2'(k);
                            hdr_only <= (frame_reg[ch][k+COMBO_NUM] == 16'h0000);
                        end
                end
                else if (ctrl_ok && rx_frame_hit[ch] && armed && !hdr_only
                    && frame_ok(fno) && frame_reg[ch][{1'b1, armed_k}] == fno)
                begin
                    armed <= 1'b0;
                    req_pulse <= 1'b1;
                end
                else if (ctrl_ok && armed && hdr_only && rb == end_reg[ch])
                begin
                    armed <= 1'b0;
                    req_pulse <= 1'b1;
                end
                else if (ctrl_ok && rx_frame_hit[ch] && !any_hdr && |trl_any)
                    req_pulse <= 1'b1;
            end
        end
        assign rx_read_req[ch] = req_pulse;

        read_req_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
            req_pulse |-> $past(rx_valid[ch] && !esc_pend && active))
            else $error("read request without a control byte");

        trailer_req_a: assert property (@(posedge clk) disable iff (sys_rst)
            active && ctrl_ok && rx_frame_hit[ch] && armed && !hdr_only && !(|hdr_hit)
            && frame_ok(fno) && frame_reg[ch][{1'b1, armed_k}] == fno
            |=> req_pulse && !armed)
            else $error("trailer did not raise read request");

        idle_no_req_a: assert property (@(posedge clk) disable iff (sys_rst)
            !active [*2] |-> !req_pulse)
            else $error("read request while frame use not ready");

        // Escape removal then text-to-binary pairing
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                rx_out_valid[ch] <= 1'b0;
                rx_out_data[ch*8 +: 8] <= 8'h00;
                nib_half <= 1'b0;
                nib_hi <= 4'h0;
            end
            else
            begin
                rx_out_valid[ch] <= 1'b0;
                if (rx_valid[ch] && (esc_pend || rb != rxesc_reg[ch][ESC_ADD_LSB +: 8]
                    || rxesc_reg[ch][ESC_ADD_LSB +: 8] == 8'h00))
                begin
                    if (conv_reg[ch] == REG_RESET)
                    begin
                        rx_out_valid[ch] <= 1'b1;
                        rx_out_data[ch*8 +: 8] <= rb;
                    end
                    else if (!nib_half)
                    begin
                        nib_hi <= from_text(rb);
                        nib_half <= 1'b1;
                    end
                    else
                    begin
                        rx_out_valid[ch] <= 1'b1;
                        rx_out_data[ch*8 +: 8] <= {nib_hi, from_text(rb)};
                        nib_half <= 1'b0;
                    end
                end
            end
        end

        // Transmit: text expansion, or escape insertion when conversion is off, one byte a cycle
        assign add_tx = txesc_reg[ch][ESC_ADD_LSB +: 8];
        assign trn_tx = txesc_reg[ch][ESC_TRN_LSB +: 8];
        assign c_hi = to_text(tx_in_data[ch*8+4 +: 4]);
        assign c_lo = to_text(tx_in_data[ch*8 +: 4]);
        assign tx_in_ready[ch] = (q_cnt == 3'd0) && (use_reg[ch] != USE_REQ);

        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                q_cnt <= 3'd0;
                tx_out_valid[ch] <= 1'b0;
                tx_out_data[ch*8 +: 8] <= 8'h00;
                for (int i = 0; i < 4; i++)
                    q_data[i] <= 8'h00;
            end
            else if (q_cnt != 3'd0)
            begin
                tx_out_valid[ch] <= 1'b1;
                tx_out_data[ch*8 +: 8] <= q_data[0];
                q_data[0] <= q_data[1];
                q_data[1] <= q_data[2];
                q_data[2] <= q_data[3];
                q_cnt <= q_cnt - 3'd1;
            end
            else
            begin
                tx_out_valid[ch] <= 1'b0;
                if (tx_in_valid[ch] && tx_in_ready[ch])
                begin
                    if (conv_reg[ch] == REG_RESET)
                    begin
                        q_data[0] <= (add_tx != 8'h00 && tx_in_data[ch*8 +: 8] == trn_tx) ? add_tx
                            : tx_in_data[ch*8 +: 8];
                        q_data[1] <= tx_in_data[ch*8 +: 8];
                        q_cnt <= (add_tx != 8'h00 && tx_in_data[ch*8 +: 8] == trn_tx) ? 3'd2
                            : 3'd1;
                    end
                    else
                    begin
                        // Hex text is never escaped, even when the codes are printable
                        q_data[0] <= c_hi;
                        q_data[1] <= c_lo;
                        q_cnt <= 3'd2;
                    end
                end
            end
        end

        no_tx_unready_a: assert property (@(posedge clk) disable iff (sys_rst)
            use_reg[ch] == USE_REQ && q_cnt == 3'd0 |=> !tx_out_valid[ch])
            else $error("transmit while frame use pending");

        text_tx_a: assert property (@(posedge clk) disable iff (sys_rst)
            q_cnt == 3'd0 && tx_in_valid[ch] && tx_in_ready[ch] && conv_reg[ch] != REG_RESET
            |=> ##1 tx_out_valid[ch] && tx_out_data[ch*8 +: 8] == to_text($past(tx_in_data[ch*8+4 +: 4], 2))
            ##1 tx_out_valid[ch])
            else $error("text conversion on transmit wrong");

        escape_tx_a: assert property (@(posedge clk) disable iff (sys_rst)
            q_cnt == 3'd0 && tx_in_valid[ch] && tx_in_ready[ch] && conv_reg[ch] == REG_RESET
            && add_tx != 8'h00 && tx_in_data[ch*8 +: 8] == trn_tx
            |=> ##1 tx_out_data[ch*8 +: 8] == $past(add_tx, 2))
            else $error("additional code not inserted");

        ready_handshake_a: assert property (@(posedge clk) disable iff (sys_rst)
            use_reg[ch] == USE_REQ && !(wr_en) |=> use_reg[ch] == USE_READY)
            else $error("frame use not promoted to ready");

        // Host request accepted at the next poll tick
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
                req_prev <= 1'b0;
            else if (mon_tick)
                req_prev <= host_req[ch];
        end
        assign host_req_ack[ch] = mon_tick && host_req[ch] && !req_prev;

        assign status_set[ST_RDREQ + ch] = req_pulse;
        assign status_set[ST_READY + ch] = (use_reg[ch] == USE_REQ) && !wr_en;
        assign status_set[ST_HOSTREQ + ch] = host_req_ack[ch];
    end

    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(status_reg[ST_RDREQ]) && mask_reg[ST_RDREQ] |-> irq)
        else $error("interrupt missing for read request");
endmodule : srufc_top

/* tb/srufc_partner.sv */
// Far-end serial device model sending framed bytes on channel 1
`timescale 1ns/10ps
module srufc_partner
    import srufc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Receive stream toward the block
    output logic [CH_NUM-1:0] rx_valid,
    output logic [CH_NUM*8-1:0] rx_data,
    output logic [CH_NUM-1:0] rx_frame_hit,
    output logic [CH_NUM*16-1:0] rx_frame_no
);
    initial
    begin
        rx_valid = '0;
        rx_data = '0;
        rx_frame_hit = '0;
        rx_frame_no = '0;
    end
    // Idle lines show the inverse so stale bytes never pass for data
    task automatic send(input logic [7:0] b, input logic h, input logic [15:0] no);
        @(posedge clk);
        rx_valid <= 2'b01;
        rx_data <= {8'h00, b};
        rx_frame_hit <= {1'b0, h};
        rx_frame_no <= {16'h0000, no};
        @(posedge clk);
        rx_valid <= 2'b00;
        rx_data <= ~{8'h00, b};
        rx_frame_hit <= 2'b00;
        rx_frame_no <= ~{16'h0000, no};
    endtask : send
endmodule : srufc_partner

/* tb/testbench.sv */
// Register and receive-frame tests of the user-frame block
`timescale 1ns/10ps
module testbench
    import srufc_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, irq;
    logic [1:0] rx_valid, rx_frame_hit, rx_out_valid, rx_read_req, tx_in_ready, tx_out_valid, ack;
    logic [15:0] rx_data, rx_out_data, tx_out_data;
    logic [31:0] rx_frame_no;
    int fails = 0, cmp_count = 0, cyc = 0, reqs = 0, acks = 0;
    logic [1:0] tx_in_valid = 2'b00, host_req = 2'b00;
    logic [15:0] tx_in_data = 16'h0000, tx_log = 16'h0000;
    logic [7:0] rx_last = 8'h00;
    always #5 clk = ~clk;
    srufc_top #(.MON_SLOW_CYC(40), .MON_QUICK_CYC(20)) u_srufc_top (.clk(clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_hit(rx_frame_hit),
        .rx_frame_no(rx_frame_no), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
        .rx_read_req(rx_read_req), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
        .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
        .host_req(host_req), .host_req_ack(ack), .irq(irq));
    srufc_partner u_srufc_partner (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_frame_hit(rx_frame_hit), .rx_frame_no(rx_frame_no));
    // Pulses are one cycle wide, so count them rather than sample late
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (rx_read_req[0] === 1'b1)
            reqs <= reqs + 1;
        if (tx_out_valid[0] === 1'b1)
            tx_log <= {tx_log[7:0], tx_out_data[7:0]};
        if (rx_out_valid[0] === 1'b1)
            rx_last <= rx_out_data[7:0];
        if (ack[0] === 1'b1)
            acks <= acks + 1;
        if (cyc == 3000)
        begin
            fails++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] i, input logic [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Holds the byte until taken, then lets the queue drain
    task automatic tx_put(input logic [7:0] d);
        @(posedge clk);
        tx_in_valid <= 2'b01;
        tx_in_data <= {8'h00, d};
        @(posedge clk);
        while (tx_in_ready[0] !== 1'b1)
            @(posedge clk);
        tx_in_valid <= 2'b00;
        repeat (4) @(posedge clk);
    endtask : tx_put
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        apb(0, IDX_USE_CH1, 16'h0);
        check(r, 32'h0);
        apb(0, 12'h3ff, 16'h0);
        check(perr, 1'b1);
        // One header+trailer pair in slots 0 and 4, out-of-range 04b0 in slot 1
        apb(1, IDX_FRAME_CH1, 16'h03e8);
        apb(1, IDX_FRAME_CH1 + 12'h4, 16'h041d);
        apb(1, IDX_FRAME_CH1 + 12'h1, 16'h04b0);
        apb(1, IDX_RXESC_CH1, 16'h1017);
        apb(1, IDX_MASK, 16'h0001);
        apb(1, IDX_MON, MON_HIGH);
        apb(0, IDX_MON, 16'h0);
        check(r, 32'h1);
        apb(1, IDX_USE_CH1, USE_REQ);
        @(posedge clk);
        check(tx_in_ready[0], 1'b0);
        apb(0, IDX_USE_CH1, 16'h0);
        check(r, {16'h0, USE_READY});
        check(tx_in_ready, 2'b11);
        apb(0, IDX_STATUS, 16'h0);
        check(r[ST_READY], 1'b1);
        u_srufc_partner.send(8'h42, 1'b1, 16'h041d);
        repeat (2) @(posedge clk);
        check(reqs, 0);
        u_srufc_partner.send(8'h41, 1'b1, 16'h03e8);
        u_srufc_partner.send(8'h42, 1'b1, 16'h041d);
        repeat (2) @(posedge clk);
        check(reqs, 1);
        check(irq, 1'b1);
        apb(1, IDX_STATUS, 16'h003f);
        @(posedge clk);
        check(irq, 1'b0);
        u_srufc_partner.send(8'h41, 1'b1, 16'h03e8);
        u_srufc_partner.send(8'h10, 1'b0, 16'h0);
        u_srufc_partner.send(8'h42, 1'b1, 16'h041d);
        repeat (2) @(posedge clk);
        check(reqs, 1);
        u_srufc_partner.send(8'h42, 1'b1, 16'h041d);
        u_srufc_partner.send(8'h55, 1'b1, 16'h04b0);
        u_srufc_partner.send(8'h00, 1'b0, 16'h0);
        repeat (2) @(posedge clk);
        check(reqs, 2);
        apb(1, IDX_TXESC_CH1, 16'h1005);
        apb(0, IDX_RXESC_CH1, 16'h0);
        check(r, 32'h1017);
        tx_put(8'h05);
        check(tx_log, 16'h1005);
        apb(1, IDX_CONV_CH1, 16'h0001);
        tx_put(8'h3c);
        check(tx_log, 16'h3343);
        u_srufc_partner.send(8'h37, 1'b0, 16'h0);
        u_srufc_partner.send(8'h41, 1'b0, 16'h0);
        repeat (2) @(posedge clk);
        check(rx_last, 8'h7a);
        // Quick polling must see a new request within twenty cycles
        host_req <= 2'b01;
        repeat (21) @(posedge clk);
        check(acks, 1);
        apb(0, IDX_STATUS, 16'h0);
        check(r[ST_HOSTREQ], 1'b1);
        give_verdict();
    end
endmodule : testbench
